/* hw/bit_exec_pkg.sv */
// Package: encodings, field positions and phase codes of the bit executor
package bit_exec_pkg;
	localparam int INSN_W = 14;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int IDX_W = 3;
	// Field positions of the 14-bit word
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 10;
	localparam int IDX_HI = 9;
	localparam int IDX_LO = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 0;
	// Top four opcode bits
	localparam logic [3:0] BIT_CLEAR_FILE_OP = 4'h4;
	localparam logic [3:0] BIT_SET_FILE_OP = 4'h5;
	localparam logic [3:0] BIT_TEST_SKIP_IF_ZERO_OP = 4'h6;
	localparam logic [1:0] PHASE_RST = 2'h0;
	// Instruction phases, Gray order decode-read-process-write
	typedef enum logic [1:0]
	{
		PH_DECODE = 2'h0,
		PH_READ = 2'h1,
		PH_PROCESS = 2'h3,
		PH_WRITE = 2'h2
	} phase_t;
	typedef enum logic [1:0]
	{
		OP_NONE = 2'h0,
		OP_CLEAR = 2'h1,
		OP_SET = 2'h3,
		OP_TEST = 2'h2
	} op_t;
endpackage

/* hw/bit_oriented_instruction_exec.sv */
// Bit-clear, bit-set and bit-test-skip execution over four phases
//
// Behaviour
// - Clear clears chosen bit, others kept
// - Set sets chosen bit, others kept
// - Clear decoded from top bits 0100
// - Status flags never touched by these
// - One word, one cycle, four phases
// - Tested bit one: next runs normally
// - Tested bit zero: next becomes idle cycle
`timescale 1ns/1ps
module bit_oriented_instruction_exec
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [bit_exec_pkg::INSN_W-1:0] insn,
	input wire logic [bit_exec_pkg::DATA_W-1:0] rd_data,
	output logic [bit_exec_pkg::ADDR_W-1:0] file_addr,
	output logic rd_en,
	output logic wr_en,
	output logic [bit_exec_pkg::DATA_W-1:0] wr_data,
	output logic status_wr_en,
	output logic skip_cycle,
	output logic cycle_end,
	output logic [1:0] phase
);
	import bit_exec_pkg::*;

	// ==========================================================
	// State
	typedef struct packed
	{
		phase_t ph;
		op_t op;
		logic [IDX_W-1:0] idx;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic skip_pend;
		logic in_skip;
		logic rd;
		logic wr;
		logic done;
		// Status write strobe; never raised, so the flags stay put
		logic stat_wr;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ==========================================================
	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.rd = 1'b0;
		s_d.wr = 1'b0;
		s_d.done = 1'b0;
		s_d.stat_wr = 1'b0;
		unique case (s_q.ph)
			PH_DECODE:
			begin
				s_d.ph = PH_READ;
				// Fetched word is discarded while a skip is pending
				s_d.in_skip = s_q.skip_pend;
				s_d.skip_pend = 1'b0;
				s_d.op = OP_NONE;
				s_d.addr = insn[ADDR_HI:ADDR_LO];
				s_d.idx = insn[IDX_HI:IDX_LO];
				if (!s_q.skip_pend)
				begin
					unique case (insn[OPC_HI:OPC_LO])
						BIT_CLEAR_FILE_OP: s_d.op = OP_CLEAR;
						BIT_SET_FILE_OP: s_d.op = OP_SET;
						BIT_TEST_SKIP_IF_ZERO_OP: s_d.op = OP_TEST;
						default: s_d.op = OP_NONE;
					endcase
				end
				s_d.rd = (s_d.op != OP_NONE);
			end
			PH_READ:
			begin
				s_d.ph = PH_PROCESS;
				s_d.data = rd_data;
			end
			PH_PROCESS:
			begin
				s_d.ph = PH_WRITE;
				// Only the addressed bit moves
				if (s_q.op == OP_CLEAR)
					s_d.data[s_q.idx] = 1'b0;
				if (s_q.op == OP_SET)
					s_d.data[s_q.idx] = 1'b1;
				if (s_q.op == OP_TEST)
					s_d.skip_pend = ~s_q.data[s_q.idx];
				s_d.wr = (s_q.op == OP_CLEAR) || (s_q.op == OP_SET);
			end
			PH_WRITE:
			begin
				s_d.ph = PH_DECODE;
				s_d.done = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Outputs straight from the state flops
	assign file_addr = s_q.addr;
	assign rd_en = s_q.rd;
	assign wr_en = s_q.wr;
	assign wr_data = s_q.data;
	assign status_wr_en = s_q.stat_wr;
	assign skip_cycle = s_q.in_skip;
	assign cycle_end = s_q.done;
	assign phase = s_q.ph;

	// ==========================================================
	// Checks
	// One-hot mask of the addressed bit, kept for the data checks
	logic [DATA_W-1:0] sel_mask;
	assign sel_mask = {{(DATA_W-1){1'b0}}, 1'b1} << s_q.idx;

	// Every check below runs on the core clock and sleeps in reset
	default clocking chk_clk @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Sequences
	// Process phase of a clear that was decoded
	sequence seq_clear_proc;
		s_q.ph == PH_PROCESS && s_q.op == OP_CLEAR;
	endsequence

	// Process phase of a set that was decoded
	sequence seq_set_proc;
		s_q.ph == PH_PROCESS && s_q.op == OP_SET;
	endsequence

	// Process phase of a test that finds the bit high
	sequence seq_test_one;
		s_q.ph == PH_PROCESS && s_q.op == OP_TEST && s_q.data[s_q.idx];
	endsequence

	// Process phase of a test that finds the bit low
	sequence seq_test_zero;
		s_q.ph == PH_PROCESS && s_q.op == OP_TEST && !s_q.data[s_q.idx];
	endsequence

	// Read, process and write follow decode, then the end pulse
	sequence seq_phase_walk;
		s_q.ph == PH_READ ##1 s_q.ph == PH_PROCESS
			##1 s_q.ph == PH_WRITE ##1 cycle_end;
	endsequence

	// A discarded word: four phases without any file access
	sequence seq_idle_cycle;
		(skip_cycle && !rd_en && !wr_en)[*4];
	endsequence

	// ==========================================================
	// Data path
	// Clear drops the chosen bit and leaves the other seven alone
	a_clear_bit: assert property (
		seq_clear_proc |=> wr_en && ((wr_data & $past(sel_mask)) == '0)
			&& ((wr_data | $past(sel_mask))
			== ($past(s_q.data) | $past(sel_mask))))
		else $error("bit clear wrote wrong data");

	// Set raises the chosen bit and leaves the other seven alone
	a_set_bit: assert property (
		seq_set_proc |=> wr_en
			&& (wr_data == ($past(s_q.data) | $past(sel_mask))))
		else $error("bit set wrote wrong data");

	// A test only looks, so nothing is written back
	a_test_no_write: assert property (
		s_q.ph == PH_PROCESS && s_q.op == OP_TEST |=> !wr_en)
		else $error("bit test wrote the file register");

	// Status flags are out of reach of all three instructions
	a_no_status: assert property (
		!status_wr_en)
		else $error("status written");

	// ==========================================================
	// Decode
	// Clear code in the top four bits selects the clear path
	a_clear_decode: assert property (
		s_q.ph == PH_DECODE && !s_q.skip_pend && insn[13:10] == 4'h4
			|=> s_q.op == OP_CLEAR)
		else $error("clear opcode not decoded");

	// Set code selects the set path
	a_set_decode: assert property (
		s_q.ph == PH_DECODE && !s_q.skip_pend && insn[13:10] == 4'h5
			|=> s_q.op == OP_SET)
		else $error("set opcode not decoded");

	// Test code selects the test path
	a_other_decode: assert property (
		s_q.ph == PH_DECODE && !s_q.skip_pend && insn[13:10] == 4'h6
			|=> s_q.op == OP_TEST)
		else $error("test opcode not decoded");

	// Any other top code is not ours: no file access starts
	a_unknown_idle: assert property (
		s_q.ph == PH_DECODE && !(insn[13:10] inside {4'h4, 4'h5, 4'h6})
			|=> !rd_en && s_q.op == OP_NONE)
		else $error("unknown opcode started an access");

	// Address and bit index come from their fixed fields
	a_field_split: assert property (
		s_q.ph == PH_DECODE |=> file_addr == $past(insn[6:0])
			&& s_q.idx == $past(insn[9:7]))
		else $error("fields taken from wrong positions");

	// ==========================================================
	// Timing
	// Decode, read, process, write: one instruction cycle
	a_four_phase: assert property (
		s_q.ph == PH_DECODE |=> seq_phase_walk)
		else $error("phase order broken");

	// The file is read only in the read phase
	a_read_phase: assert property (
		rd_en |-> s_q.ph == PH_READ)
		else $error("read outside the read phase");

	// Write-back only in the write phase, so one word per cycle
	a_write_phase: assert property (
		wr_en |-> s_q.ph == PH_WRITE)
		else $error("write outside the write phase");

	// Tested bit high: the next word runs as fetched
	a_no_skip: assert property (
		seq_test_one |=> ##2 !skip_cycle)
		else $error("skip taken on set bit");

	// Tested bit low: the next word gives way to four idle phases
	a_skip_idle: assert property (
		seq_test_zero |=> ##2 seq_idle_cycle)
		else $error("skip cycle not idle");

	// A pending skip throws the fetched word away undecoded
	a_skip_drop: assert property (
		s_q.ph == PH_DECODE && s_q.skip_pend |=> s_q.op == OP_NONE)
		else $error("discarded word was decoded");
endmodule // bit_oriented_instruction_exec

/* test/reg_file_model.sv */
// Register file model facing the bit executor
`timescale 1ns/1ps
module reg_file_model
(
	input wire logic mclk,
	input wire logic [6:0] file_addr,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	logic [7:0] mem [128];
	// Outside reads show the inverse, so stale data never passes
	assign rd_data = rd_en ? mem[file_addr] : ~mem[file_addr];
	// Write-back lands at the end of the write phase
	always @(posedge mclk)
	begin
		if (wr_en)
			mem[file_addr] <= wr_data;
	end
endmodule // reg_file_model

/* test/testbench.sv */
// Random self-checking bench of the bit executor
`timescale 1ns/1ps
module testbench;
	import bit_exec_pkg::*;
	logic mclk = 0, sys_rst = 1, skip_q = 0;
	logic [13:0] insn = 14'h0000;
	logic [7:0] rd_data, wr_data, e;
	logic [7:0] sh [128];
	logic [6:0] file_addr;
	logic rd_en, wr_en, status_wr_en, skip_cycle, cycle_end;
	logic [1:0] phase;
	int err_count = 0, n_tests = 0, cyc = 0, seed = 41017, r;
	bit_oriented_instruction_exec dut (.mclk, .sys_rst, .insn, .rd_data,
		.file_addr, .rd_en, .wr_en, .wr_data, .status_wr_en, .skip_cycle,
		.cycle_end, .phase);
	reg_file_model pm (.mclk, .file_addr, .rd_en, .wr_en, .wr_data,
		.rd_data);
	initial forever #2 mclk = ~mclk;
	task wrap_up;
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] x);
		n_tests++;
		if (g !== x)
		begin
			err_count++;
			$display("MISMATCH %0t %h %h", $time, g, x);
		end
	endtask
	// One word per instruction cycle, checked in the decode, read and write phases
	task step(input logic [3:0] op, input logic [2:0] b, input logic [6:0] f);
		logic act;
		act = op inside {4'h4, 4'h5, 4'h6} && !skip_q;
		do @(posedge mclk); while (phase !== PH_WRITE);
		insn <= {op, b, f};
		e = sh[f];
		e[b] = (op == BIT_SET_FILE_OP);
		#1 chk({cycle_end, phase}, {1'b1, PH_DECODE});
		@(posedge mclk);
		#1 chk({phase, skip_cycle}, {PH_READ, skip_q});
		chk(rd_en, act);
		if (act)
			chk({1'b0, file_addr}, {1'b0, f});
		repeat (2) @(posedge mclk);
		#1 chk({phase, status_wr_en}, {PH_WRITE, 1'b0});
		chk(wr_en, act && op != 4'h6);
		if (act && op != 4'h6)
			chk(wr_data, e);
		if (act && op != 4'h6)
			sh[f] = e;
		skip_q = act && op == 4'h6 && !sh[f][b];
	endtask
	// Hang guard well above the expected run
	always @(posedge mclk)
	begin
		if (++cyc == 5000)
		begin
			err_count++;
			wrap_up;
		end
	end
	initial
	begin
		for (int i = 0; i < 128; i++)
		begin
			sh[i] = 8'($random(seed));
			pm.mem[i] = sh[i];
		end
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		// Corners: clear then test skips, set then test runs on
		step(4'h4, 3'h7, 7'h7F);
		step(4'h6, 3'h7, 7'h7F);
		step(4'h5, 3'h0, 7'h00);
		step(4'h5, 3'h0, 7'h00);
		step(4'h6, 3'h0, 7'h00);
		repeat (200)
		begin
			r = $random(seed);
			step(4'h4 + 4'(r[1:0]), r[4:2], r[11:5]);
		end
		wrap_up;
	end
endmodule // testbench
